// ===== pin_partner.sv
`timescale 1ns/1ps
`default_nettype none

module pin_partner (
	input  wire logic       clk,
	input  wire logic       ext_run,
	input  wire logic [1:0] cap_lvl,
	output var  logic       ext_clk,
	output var  logic [1:0] cap_pin
);
	logic ph_r;

	initial ph_r = 1'b0;
	initial ext_clk = 1'b0;

	// Event pulses at a quarter of the CPU rate, still outside bursts
	// Pin levels change only right after a rising edge, as real pins would be driven
	always @(posedge clk) begin
		cap_pin <= cap_lvl;
		ph_r <= ext_run ? ~ph_r : 1'b0;
		if (ext_run && ph_r) begin
			ext_clk <= ~ext_clk;
		end
	end

endmodule

`default_nettype wire

// ===== pwm_reload_timer.sv
// Operation
// - External clock select bit feeds prescaler from CPU clock (0) or external pin (1).
// - Tap select divides prescaler input by two to the power of its value.
// - Run enable low freezes counter and prescaler; high lets the counter run.
// - Force reload is write-only, reads zero, loads reload value, clears prescaler.
// - Wrap interrupt enable gates the request coming from the wrap flag.
// - Wrap flag sets on FFh to reload transition; reading control/status clears it.
// - Live counter reads current count and overwrites it when written, even running.
// - Each overflow reloads counter and sets every enabled PWM output to its overflow level.
// - Reload of zero gives full 8-bit resolution; larger values shorten the period.
// - Four pin enable bits connect or disconnect each channel's PWM output.
// - Count at or below shadow compare gives output 1 for polarity 0, else 0.
// - Changing a polarity bit inverts that output at once.
// - Duty register feeds shadow compare for second edge; reload sets the first.
// - Top two capture control/status bits are reserved and read zero.
// - Capture edge select: 0 falling edge, 1 rising edge triggers capture.
// - Per-channel capture interrupt enable gates the request from its capture flag.
// - Capture sets the channel flag; reading its capture value register clears it.
// - Capture value registers are read-only and hold the count at last capture.
// - Every register resets to all zeros.
// - Shadow compares are hidden and load from duty registers at each overflow.
// - Count passing shadow compare ends the active phase of that channel.
// - After a capture, further captures are blocked until the value is read.
// - Capture inputs are synchronised to the CPU clock before latching the count.
`timescale 1ns/1ps
`default_nettype none

module pwm_reload_timer (
	input  wire  logic                 CLK_SYS,
	input  wire  logic                 RST,
	input  wire  pwmtmr_pkg::bus_req_s BUS,
	output var   logic [7:0]           RDATA,
	input  wire  logic                 EXT_CLK_IN,
	input  wire  logic [1:0]           CAPTURE_IN_PIN,
	output var   logic [3:0]           PWM_OUT_PIN,
	output var   logic [3:0]           PWM_OUT_PIN_OE,
	output var   logic                 IRQ
);

	pwmtmr_pkg::state_s st_r;
	pwmtmr_pkg::state_s st_nxt;

	logic       wr_ctrl;
	logic       rd_ctrl;
	logic       wr_live;
	logic       force_reload;
	logic [1:0] rd_cap_val;
	logic       in_tick;
	logic       cnt_tick;
	logic       wrap_ev;
	logic [6:0] tap_mask;
	logic [1:0] cap_edge_seen;
	logic [1:0] cap_take;
	logic [3:0] active;

	assign wr_ctrl       = BUS.wr && (BUS.addr == pwmtmr_pkg::OFS_TIMER_CS);
	assign rd_ctrl       = BUS.rd && (BUS.addr == pwmtmr_pkg::OFS_TIMER_CS);
	assign wr_live       = BUS.wr && (BUS.addr == pwmtmr_pkg::OFS_LIVE_CNT);
	assign force_reload  = wr_ctrl && BUS.wdata[pwmtmr_pkg::BIT_FORCE_RELOAD];
	assign rd_cap_val[0] = BUS.rd && (BUS.addr == pwmtmr_pkg::OFS_CAP_VAL_CH1);
	assign rd_cap_val[1] = BUS.rd && (BUS.addr == pwmtmr_pkg::OFS_CAP_VAL_CH2);

	always_comb begin
		st_nxt = st_r;

		// Pin synchronisers: a change counts once the second and third stages agree
		st_nxt.ext_sync = {st_r.ext_sync[1:0], EXT_CLK_IN};
		if (st_r.ext_sync[1] == st_r.ext_sync[2]) begin
			st_nxt.ext_lvl = st_r.ext_sync[2];
		end
		for (int i = 0; i < 2; i++) begin
			st_nxt.cap_sync[i] = {st_r.cap_sync[i][1:0], CAPTURE_IN_PIN[i]};
			if (st_r.cap_sync[i][1] == st_r.cap_sync[i][2]) begin
				st_nxt.cap_lvl[i] = st_r.cap_sync[i][2];
			end
		end

		if (st_r.ext_sel) begin
			in_tick = st_nxt.ext_lvl && !st_r.ext_lvl;
		end else begin
			in_tick = 1'b1;
		end

		// tap select mask, counter advances when the selected low bits are all ones
		tap_mask = ~(7'(pwmtmr_pkg::PRESC_ONES << st_r.tap_sel));
		// counter and prescaler do not count while run enable is low
		cnt_tick = st_r.run && in_tick && ((st_r.presc & tap_mask) == tap_mask);
		wrap_ev  = cnt_tick && (st_r.cnt == pwmtmr_pkg::COUNT_TOP);

		if (st_r.run && in_tick) begin
			st_nxt.presc = st_r.presc + 7'h01;
		end
		if (cnt_tick) begin
			if (wrap_ev) begin
				st_nxt.cnt = st_r.reload;
			end else begin
				st_nxt.cnt = st_r.cnt + 8'h01;
			end
		end
		if (wrap_ev) begin
			// shadow compares follow duty registers only at overflow
			st_nxt.shadow = st_r.duty;
		end

		// wrap flag, set wins over the read clear
		if (rd_ctrl) begin
			st_nxt.wrap_flag = 1'b0;
		end
		if (wrap_ev) begin
			st_nxt.wrap_flag = 1'b1;
		end

		// Capture channels
		for (int i = 0; i < 2; i++) begin
			if (st_r.cap_edge[i]) begin
				cap_edge_seen[i] = st_nxt.cap_lvl[i] && !st_r.cap_lvl[i];
			end else begin
				cap_edge_seen[i] = !st_nxt.cap_lvl[i] && st_r.cap_lvl[i];
			end
			// blocked while flag stands unless it is read in this cycle
			cap_take[i] = cap_edge_seen[i] && (!st_r.cap_flag[i] || rd_cap_val[i]);
			// read clears, capture sets and wins
			if (rd_cap_val[i]) begin
				st_nxt.cap_flag[i] = 1'b0;
			end
			if (cap_take[i]) begin
				st_nxt.cap_flag[i] = 1'b1;
				st_nxt.cap_val[i] = st_r.cnt;
			end
		end

		// Register writes; software wins over counting in the same cycle
		if (BUS.wr) begin
			unique case (BUS.addr)
				pwmtmr_pkg::OFS_DUTY_CH3: begin
					st_nxt.duty[3] = BUS.wdata;
				end
				pwmtmr_pkg::OFS_DUTY_CH2: begin
					st_nxt.duty[2] = BUS.wdata;
				end
				pwmtmr_pkg::OFS_DUTY_CH1: begin
					st_nxt.duty[1] = BUS.wdata;
				end
				pwmtmr_pkg::OFS_DUTY_CH0: begin
					st_nxt.duty[0] = BUS.wdata;
				end
				pwmtmr_pkg::OFS_PWM_CTRL: begin
					st_nxt.pin_en   = BUS.wdata[7:pwmtmr_pkg::BIT_PIN_EN_LO];
					st_nxt.polarity = BUS.wdata[pwmtmr_pkg::BIT_PIN_EN_LO-1:0];
				end
				pwmtmr_pkg::OFS_TIMER_CS: begin
					st_nxt.ext_sel     = BUS.wdata[pwmtmr_pkg::BIT_EXT_CLOCK_SEL];
					st_nxt.tap_sel     = BUS.wdata[pwmtmr_pkg::BIT_TAP_SEL_HI:
						pwmtmr_pkg::BIT_TAP_SEL_LO];
					st_nxt.run         = BUS.wdata[pwmtmr_pkg::BIT_RUN_ENABLE];
					st_nxt.wrap_irq_en = BUS.wdata[pwmtmr_pkg::BIT_WRAP_IRQ_EN];
					if (force_reload) begin
						st_nxt.cnt   = st_r.reload;
						st_nxt.presc = pwmtmr_pkg::RST_PRESC;
					end
				end
				pwmtmr_pkg::OFS_LIVE_CNT: begin
					// overwrite counter on the fly, prescaler restarts
					st_nxt.cnt   = BUS.wdata;
					st_nxt.presc = pwmtmr_pkg::RST_PRESC;
				end
				pwmtmr_pkg::OFS_RELOAD: begin
					st_nxt.reload = BUS.wdata;
				end
				pwmtmr_pkg::OFS_CAPTURE_CS: begin
					st_nxt.cap_edge   = BUS.wdata[pwmtmr_pkg::BIT_CAP_EDGE_LO+1:
						pwmtmr_pkg::BIT_CAP_EDGE_LO];
					st_nxt.cap_irq_en = BUS.wdata[pwmtmr_pkg::BIT_CAP_IRQ_EN_LO+1:
						pwmtmr_pkg::BIT_CAP_IRQ_EN_LO];
				end
				default: begin
				end
			endcase
		end

		// Read data, presented in the cycle after the strobe
		st_nxt.rdata = pwmtmr_pkg::RST_REG;
		if (BUS.rd) begin
			unique case (BUS.addr)
				pwmtmr_pkg::OFS_DUTY_CH3: begin
					st_nxt.rdata = st_r.duty[3];
				end
				pwmtmr_pkg::OFS_DUTY_CH2: begin
					st_nxt.rdata = st_r.duty[2];
				end
				pwmtmr_pkg::OFS_DUTY_CH1: begin
					st_nxt.rdata = st_r.duty[1];
				end
				pwmtmr_pkg::OFS_DUTY_CH0: begin
					st_nxt.rdata = st_r.duty[0];
				end
				pwmtmr_pkg::OFS_PWM_CTRL: begin
					st_nxt.rdata = {st_r.pin_en, st_r.polarity};
				end
				pwmtmr_pkg::OFS_TIMER_CS: begin
					st_nxt.rdata = {st_r.ext_sel, st_r.tap_sel, st_r.run, 1'b0,
						st_r.wrap_irq_en, st_r.wrap_flag};
				end
				pwmtmr_pkg::OFS_LIVE_CNT: begin
					st_nxt.rdata = st_r.cnt;
				end
				pwmtmr_pkg::OFS_RELOAD: begin
					st_nxt.rdata = st_r.reload;
				end
				pwmtmr_pkg::OFS_CAPTURE_CS: begin
					st_nxt.rdata = {2'b00, st_r.cap_edge, st_r.cap_irq_en, st_r.cap_flag};
				end
				pwmtmr_pkg::OFS_CAP_VAL_CH1: begin
					st_nxt.rdata = st_r.cap_val[0];
				end
				pwmtmr_pkg::OFS_CAP_VAL_CH2: begin
					st_nxt.rdata = st_r.cap_val[1];
				end
				default: begin
				end
			endcase
		end

		// reload is the first edge, shadow compare the second
		for (int i = 0; i < 4; i++) begin
			// active phase ends once the count passes the shadow compare
			// a zero reload spans all 256 counts
			active[i] = (st_r.cnt <= st_r.shadow[i]);
			// polarity applied after the compare, so a change acts at once
			// disconnected pins are released and driven low
			st_nxt.pwm_out[i] = st_r.pin_en[i] && (active[i] ^ st_r.polarity[i]);
			st_nxt.pwm_oe[i]  = st_r.pin_en[i];
		end

		st_nxt.irq = (st_r.wrap_flag && st_r.wrap_irq_en)
			|| |(st_r.cap_flag & st_r.cap_irq_en);
	end

	always_ff @(posedge CLK_SYS) begin
		if (RST) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign RDATA          = st_r.rdata;
	assign PWM_OUT_PIN    = st_r.pwm_out;
	assign PWM_OUT_PIN_OE = st_r.pwm_oe;
	assign IRQ            = st_r.irq;

	default clocking cb @(posedge CLK_SYS);
	endclocking
	default disable iff (RST);

	force_reload_a: assert property (
		force_reload |=> (st_r.cnt == $past(st_r.reload)) && (st_r.presc == 7'h00))
		else $error("force reload did not load counter and clear prescaler");

	force_reload_reads_zero_a: assert property (
		rd_ctrl |=> (RDATA[pwmtmr_pkg::BIT_FORCE_RELOAD] == 1'b0))
		else $error("force reload bit read back non-zero");

	run_freeze_a: assert property (
		(!st_r.run && !BUS.wr) |=> ($stable(st_r.cnt) && $stable(st_r.presc)))
		else $error("counter moved while stopped");

	wrap_reload_a: assert property (
		(wrap_ev && !BUS.wr) |=> (st_r.cnt == $past(st_r.reload)) && st_r.wrap_flag)
		else $error("wrap did not reload counter or set flag");

	wrap_clear_a: assert property (
		(rd_ctrl && !wrap_ev && st_r.wrap_flag) |=> !st_r.wrap_flag ##1 1'b1)
		else $error("wrap flag not cleared by status read");

	live_write_a: assert property (
		wr_live |=> (st_r.cnt == $past(BUS.wdata)))
		else $error("live counter write lost");

	shadow_load_a: assert property (
		!$stable(st_r.shadow) |-> $past(wrap_ev))
		else $error("shadow compare changed outside overflow");

	cap_reserved_a: assert property (
		(BUS.rd && BUS.addr == pwmtmr_pkg::OFS_CAPTURE_CS) |=> (RDATA[7:6] == 2'b00))
		else $error("reserved capture bits read non-zero");

	cap_hold_a: assert property (
		(st_r.cap_flag[0] && !rd_cap_val[0]) |=> $stable(st_r.cap_val[0]))
		else $error("capture value overwritten while flag set");

	pwm_level_a: assert property (
		PWM_OUT_PIN[0] == $past(st_r.pin_en[0]
			&& ((st_r.cnt <= st_r.shadow[0]) ^ st_r.polarity[0])))
		else $error("channel 0 level does not match compare and polarity");

	pin_off_a: assert property (
		!st_r.pin_en[1] |=> (!PWM_OUT_PIN[1] && !PWM_OUT_PIN_OE[1]))
		else $error("disabled channel 1 still driven");

	irq_gate_a: assert property (
		(!st_r.wrap_irq_en && !(|st_r.cap_irq_en)) |=> !IRQ)
		else $error("interrupt raised with all enables off");

endmodule

`default_nettype wire

// ===== pwmtmr_pkg.sv
package pwmtmr_pkg;

	// Register offsets
	localparam logic [7:0] OFS_DUTY_CH3    = 8'h31;
	localparam logic [7:0] OFS_DUTY_CH2    = 8'h32;
	localparam logic [7:0] OFS_DUTY_CH1    = 8'h33;
	localparam logic [7:0] OFS_DUTY_CH0    = 8'h34;
	localparam logic [7:0] OFS_PWM_CTRL    = 8'h35;
	localparam logic [7:0] OFS_TIMER_CS    = 8'h36;
	localparam logic [7:0] OFS_LIVE_CNT    = 8'h37;
	localparam logic [7:0] OFS_RELOAD      = 8'h38;
	localparam logic [7:0] OFS_CAPTURE_CS  = 8'h39;
	localparam logic [7:0] OFS_CAP_VAL_CH1 = 8'h3A;
	localparam logic [7:0] OFS_CAP_VAL_CH2 = 8'h3B;

	// Field positions in timer_ctrl_status
	localparam int BIT_EXT_CLOCK_SEL = 7;
	localparam int BIT_TAP_SEL_HI    = 6;
	localparam int BIT_TAP_SEL_LO    = 4;
	localparam int BIT_RUN_ENABLE    = 3;
	localparam int BIT_FORCE_RELOAD  = 2;
	localparam int BIT_WRAP_IRQ_EN   = 1;
	localparam int BIT_WRAP_FLAG     = 0;

	// Field positions in pwm_output_control and capture_ctrl_status
	localparam int BIT_PIN_EN_LO     = 4;
	localparam int BIT_CAP_EDGE_LO   = 4;
	localparam int BIT_CAP_IRQ_EN_LO = 2;

	// Reset values and count limits
	localparam logic [7:0] RST_REG    = 8'h00;
	localparam logic [6:0] RST_PRESC  = 7'h00;
	localparam logic [7:0] COUNT_TOP  = 8'hFF;
	localparam logic [6:0] PRESC_ONES = 7'h7F;

	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} bus_req_s;

	typedef struct packed {
		logic       ext_sel;
		logic [2:0] tap_sel;
		logic       run;
		logic       wrap_irq_en;
		logic       wrap_flag;
		logic [7:0] cnt;
		logic [6:0] presc;
		logic [7:0] reload;
		logic [3:0][7:0] duty;
		logic [3:0][7:0] shadow;
		logic [3:0] pin_en;
		logic [3:0] polarity;
		logic [1:0] cap_edge;
		logic [1:0] cap_irq_en;
		logic [1:0] cap_flag;
		logic [1:0][7:0] cap_val;
		logic [2:0] ext_sync;
		logic       ext_lvl;
		logic [1:0][2:0] cap_sync;
		logic [1:0] cap_lvl;
		logic [7:0] rdata;
		logic [3:0] pwm_out;
		logic [3:0] pwm_oe;
		logic       irq;
	} state_s;

endpackage

// ===== tb.sv
`timescale 1ns/1ps
`default_nettype none

module tb;
	logic                 clk_sys     = 1'b0;
	logic                 rst         = 1'b1;
	pwmtmr_pkg::bus_req_s bus         = '0;
	logic [7:0]           rdata;
	logic                 ext_clk;
	logic                 ext_run     = 1'b0;
	logic [1:0]           cap_lvl     = 2'b01;
	logic [1:0]           cap_pin;
	logic [3:0]           pwm;
	logic [3:0]           pwm_oe;
	logic                 irq;
	logic [7:0]           v;
	logic [7:0]           highs [4];
	logic [7:0]           duty [4]    = '{8'hF8, 8'hF4, 8'hF0, 8'hFF};
	int                   num_errors  = 0;
	int                   comparisons = 0;

	always #25 clk_sys = ~clk_sys;

	pwm_reload_timer u_pwm_reload_timer (
		.CLK_SYS        (clk_sys),
		.RST            (rst),
		.BUS            (bus),
		.RDATA          (rdata),
		.EXT_CLK_IN     (ext_clk),
		.CAPTURE_IN_PIN (cap_pin),
		.PWM_OUT_PIN    (pwm),
		.PWM_OUT_PIN_OE (pwm_oe),
		.IRQ            (irq)
	);

	pin_partner u_pin_partner (
		.clk     (clk_sys),
		.ext_run (ext_run),
		.cap_lvl (cap_lvl),
		.ext_clk (ext_clk),
		.cap_pin (cap_pin)
	);

	task automatic summarize();
		$display("comparisons %0d mismatches %0d", comparisons, num_errors);
		if (num_errors == 0 && comparisons > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		comparisons++;
		if (got !== exp) begin
			num_errors++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic rng(input logic [7:0] got, input logic [7:0] lo, input logic [7:0] up);
		comparisons++;
		if ((got >= lo && got <= up) !== 1'b1) begin
			num_errors++;
			$display("mismatch at %0t: got %h outside %h..%h", $time, got, lo, up);
		end
	endtask

	task automatic run(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge clk_sys);
		bus.wr <= 1'b0;
	endtask

	// Read data stand only in the cycle after the strobe
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk_sys);
		bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(posedge clk_sys);
		bus.rd <= 1'b0;
		#1 d = rdata;
	endtask

	task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
		rd(a, v);
		chk(v, exp);
	endtask

	task automatic wait_flag(input logic [7:0] m);
		for (int n = 0; n < 16; n++) begin
			rd(8'h39, v);
			if ((v & m) === m)
				return;
		end
		num_errors++;
		$display("mismatch at %0t: capture flag never set", $time);
		summarize();
	endtask

	// Counts high cycles per channel over one 16-count period
	task automatic pwm_chk(input logic [3:0] en, input logic [3:0] pol);
		logic [7:0] k;
		run(2);
		for (int i = 0; i < 4; i++)
			highs[i] = 8'h00;
		repeat (16) begin
			run(1);
			for (int i = 0; i < 4; i++)
				highs[i] += {7'h00, pwm[i]};
		end
		for (int i = 0; i < 4; i++) begin
			k = duty[i] - 8'hEF;
			chk(highs[i], en[i] ? (pol[i] ? 8'h10 - k : k) : 8'h00);
		end
		chk({4'h0, pwm_oe}, {4'h0, en});
	endtask

	task automatic t_access();
		for (int a = 8'h30; a <= 8'h3C; a++)
			rchk(8'(a), 8'h00);
		wr(8'h38, 8'h5A);
		wr(8'h36, 8'h04);
		rchk(8'h36, 8'h00);
		rchk(8'h37, 8'h5A);
		wr(8'h37, 8'h33);
		rchk(8'h37, 8'h33);
		wr(8'h3A, 8'h77);
		rchk(8'h3A, 8'h00);
		wr(8'h39, 8'hFF);
		rchk(8'h39, 8'h3C);
		wr(8'h39, 8'h00);
		run(20);
		rchk(8'h37, 8'h33);
		$display("test access done");
	endtask

	task automatic t_presc();
		wr(8'h37, 8'h00);
		wr(8'h36, 8'h38);
		run(63);
		wr(8'h36, 8'h00);
		rd(8'h37, v);
		rng(v, 8'h07, 8'h09);
		wr(8'h37, 8'h00);
		wr(8'h36, 8'h88);
		ext_run <= 1'b1;
		run(40);
		ext_run <= 1'b0;
		run(8);
		wr(8'h36, 8'h00);
		rchk(8'h37, 8'h0A);
		$display("test prescaler done");
	endtask

	task automatic t_wrap();
		wr(8'h38, 8'h00);
		wr(8'h37, 8'hFD);
		wr(8'h36, 8'h0A);
		run(10);
		chk({7'h00, irq}, 8'h01);
		rchk(8'h36, 8'h0B);
		rchk(8'h36, 8'h0A);
		run(2);
		chk({7'h00, irq}, 8'h00);
		wr(8'h36, 8'h00);
		wr(8'h37, 8'hFD);
		wr(8'h36, 8'h08);
		run(10);
		chk({7'h00, irq}, 8'h00);
		rchk(8'h36, 8'h09);
		wr(8'h36, 8'h00);
		$display("test wrap done");
	endtask

	task automatic t_pwm();
		wr(8'h38, 8'hF0);
		for (int i = 0; i < 4; i++)
			wr(8'h34 - 8'(i), duty[i]);
		wr(8'h35, 8'hF0);
		wr(8'h36, 8'h0C);
		run(40);
		pwm_chk(4'hF, 4'h0);
		wr(8'h35, 8'h5F);
		pwm_chk(4'h5, 4'hF);
		$display("test pwm done");
	endtask

	task automatic t_capture();
		wr(8'h39, 8'h04);
		cap_lvl[0] <= 1'b0;
		wait_flag(8'h01);
		chk({7'h00, irq}, 8'h01);
		rd(8'h3A, v);
		rng(v, 8'hF0, 8'hFF);
		rchk(8'h39, 8'h04);
		wr(8'h39, 8'h20);
		cap_lvl <= 2'b11;
		wait_flag(8'h02);
		chk({7'h00, irq}, 8'h00);
		rd(8'h3B, v);
		rchk(8'h39, 8'h20);
		$display("test capture done");
	endtask

	initial begin
		repeat (20000) @(posedge clk_sys);
		num_errors++;
		$display("mismatch at %0t: run timed out", $time);
		summarize();
	end

	initial begin
		repeat (20) @(posedge clk_sys);
		rst <= 1'b0;
		t_access();
		t_presc();
		t_wrap();
		t_pwm();
		t_capture();
		summarize();
	end
endmodule

`default_nettype wire
